// ---- common/ccr_pkg.sv ----
// constants for the charger configuration register bank
package ccr_pkg;
   // register offsets (low byte; the controller side prefixes the page byte)
   localparam logic [7:0] OFS_INPUT_LIMIT = 8'h90;
   localparam logic [7:0] OFS_CHARGE_CFG = 8'h91;
   localparam logic [7:0] OFS_TERM_CTL = 8'h92;
   localparam logic [7:0] OFS_LOCKOUT_REC = 8'h93;
   localparam logic [7:0] UC_PAGE = 8'hA0;
   // reset values
   localparam logic [7:0] RST_INPUT_LIMIT = 8'h80;
   localparam logic [7:0] RST_CHARGE_CFG = 8'h00;
   localparam logic [7:0] RST_TERM_CTL = 8'h04;
   localparam logic [7:0] RST_LOCKOUT_REC = 8'h78;
   // field positions
   localparam int LIM_CODE_LSB = 0;
   localparam int LIM_SRC_BIT = 7;
   localparam int CUR_CODE_LSB = 0;
   localparam int VOL_CODE_LSB = 4;
   localparam int TERM_METH_LSB = 0;
   localparam int TERM_TIMER_LSB = 2;
   localparam int TERMINATION_CURRENT_SELECT_BIT = 7;
   localparam int UVLO_BIT = 0;
   localparam int BATGD_LSB = 3;
   localparam int REC_CUR_LSB = 5;
   // timing: one minute at 50 MHz, and timer units of 2 and 10 minutes
   localparam int CLK_HZ = 50000000;
   localparam int SECONDS_PER_MINUTE = 60;
   localparam longint MINUTE_CYCLES = longint'(CLK_HZ) * SECONDS_PER_MINUTE;
   localparam int SHORT_UNIT_MIN = 2;
   localparam int LONG_UNIT_MIN = 10;
   // current and voltage figures in mA and mV
   localparam logic [11:0] MA_100 = 12'h064;
   localparam logic [11:0] MA_50 = 12'h032;
   localparam logic [11:0] MA_25 = 12'h019;
   localparam logic [11:0] MA_500 = 12'h1F4;
   localparam logic [11:0] MA_1000 = 12'h3E8;
   localparam logic [11:0] MA_1500 = 12'h5DC;
   localparam logic [11:0] MA_2000 = 12'h7D0;
   // voltage figures; the float and lockout levels need 13 bits (4.2 V is above 4095 mV)
   localparam logic [12:0] MV_4100 = 13'h1004;
   localparam logic [12:0] MV_4150 = 13'h1036;
   localparam logic [12:0] MV_4200 = 13'h1068;
   localparam logic [12:0] MV_3950 = 13'h0F6E;
   localparam logic [11:0] MV_2500 = 12'h9C4;
   localparam logic [11:0] MV_100 = 12'h064;
   // termination methods
   typedef enum logic [1:0] {
      TERM_TIMER_AT_ITERM = 2'b00,
      TERM_TIMER_AT_CV = 2'b01,
      TERM_AT_ITERM = 2'b10,
      TERM_EITHER = 2'b11
   } ccr_term_e;
endpackage

// ---- rtl/ccr_limit_decode.sv ----
// decode of the input current limit selection
`timescale 1ns/1ps
`default_nettype none
module ccr_limit_decode (
   // register fields
   input wire logic limitSourceSelect,
   input wire logic [2:0] inputLimitCode,
   // pin side
   input wire logic pinFunctionSelect,
   input wire logic sharedLimitPin,
   // result
   output logic [11:0] inputLimitMa,
   output logic inputLimitValid
);
   // source bit picks the pin path or the coded path
   always_comb begin
      inputLimitMa = 12'h000;
      inputLimitValid = 1'b0;
      if (!limitSourceSelect) begin
         // pin path only when the pin is set to this function
         inputLimitValid = pinFunctionSelect;
         if (pinFunctionSelect) begin
            inputLimitMa = sharedLimitPin ? ccr_pkg::MA_1500 : ccr_pkg::MA_500;
         end
      end else begin
         inputLimitValid = 1'b1;
         case (inputLimitCode)
            3'h0: inputLimitMa = ccr_pkg::MA_100;
            3'h1: inputLimitMa = ccr_pkg::MA_500;
            3'h2: inputLimitMa = ccr_pkg::MA_1000;
            3'h3: inputLimitMa = ccr_pkg::MA_1500;
            3'h4: inputLimitMa = ccr_pkg::MA_2000;
            default: inputLimitValid = 1'b0;
         endcase
      end
   end
endmodule // ccr_limit_decode
`default_nettype wire

// ---- rtl/ccr_term_ctrl.sv ----
// termination timer and end-of-charge decision
`timescale 1ns/1ps
`default_nettype none
module ccr_term_ctrl #(
   parameter longint MINUTE_CYCLES = ccr_pkg::MINUTE_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // settings
   input wire logic [1:0] terminationMethod,
   input wire logic [4:0] termTimerCode,
   // charger conditions
   input wire logic charging,
   input wire logic cvMode,
   input wire logic atTermCurrent,
   // result
   output logic chargeDone,
   output logic timerRunning
);
   typedef struct packed {
      logic [39:0] minuteCount;
      logic [8:0] minutes;
      logic running;
      logic done;
   } ccr_term_s;
   ccr_term_s st;
   ccr_term_s next_st;
   logic [8:0] limitMinutes;
   logic startCond;
   logic expired;
   // timer length in minutes
   always_comb begin
      if (terminationMethod[0]) begin
         limitMinutes = 9'(termTimerCode) * 9'(ccr_pkg::LONG_UNIT_MIN);
      end else begin
         limitMinutes = 9'(termTimerCode) * 9'(ccr_pkg::SHORT_UNIT_MIN);
      end
   end
   // start condition: current reached for 00, CV entry for x1
   assign startCond = (terminationMethod == ccr_pkg::TERM_TIMER_AT_ITERM) ? atTermCurrent
                    : (terminationMethod[0] ? cvMode : 1'b0);
   assign expired = st.running && (st.minutes >= limitMinutes);
   // timer and done latch; done clears when charging stops
   always_comb begin
      next_st = st;
      if (!charging) begin
         next_st = '0;
      end else if (!st.done) begin
         if (st.running) begin
            if (st.minuteCount == 40'(MINUTE_CYCLES - 1)) begin
               next_st.minuteCount = '0;
               next_st.minutes = st.minutes + 9'h001;
            end else begin
               next_st.minuteCount = st.minuteCount + 40'h1;
            end
         end else if (startCond) begin
            next_st.running = 1'b1;
         end
         case (terminationMethod)
            ccr_pkg::TERM_TIMER_AT_ITERM: next_st.done = expired;
            ccr_pkg::TERM_TIMER_AT_CV: next_st.done = expired;
            ccr_pkg::TERM_AT_ITERM: next_st.done = atTermCurrent;
            ccr_pkg::TERM_EITHER: next_st.done = expired || atTermCurrent;
            default: next_st.done = 1'b0;
         endcase
      end
   end
   // state register
   always_ff @(posedge clk) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign chargeDone = st.done;
   assign timerRunning = st.running;
endmodule // ccr_term_ctrl
`default_nettype wire

// ---- rtl/ccr_config_bank.sv ----
// charger configuration register bank with decoded charger settings
//
// Behaviour
// - registers are 8 bits, whole-byte writes
// - answer at page-0 offset and 0xA0 address
// - pin source: low 500mA, high 1500mA
// - coded limit 100 to 2000mA, rest invalid
// - charge current code times 100mA, min 100
// - float voltage 4.10, 4.15, 4.20 V
// - method 00: timer starts at termination current
// - method 01: timer starts at CV entry
// - method 10: end at termination current
// - method 11: timer or current, first wins
// - method 00: timer code times 2 minutes
// - method x1: timer code times 10 minutes
// - termination current 100mA or 50mA
// - lockout threshold 3.95 V or 4.15 V
// - below battery-good threshold use recovery current
// - battery-good threshold 2.50 to 2.80 V
// - recovery current 25 to 175 mA
`timescale 1ns/1ps
`default_nettype none
module ccr_config_bank #(
   parameter longint MINUTE_CYCLES = ccr_pkg::MINUTE_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // serial host register port, page 0
   input wire logic hostWrite,
   input wire logic hostRead,
   input wire logic [7:0] hostAddr,
   input wire logic [7:0] hostWdata,
   output logic [7:0] hostRdata,
   output logic hostHit,
   // controller register port
   input wire logic ucWrite,
   input wire logic ucRead,
   input wire logic [15:0] ucAddr,
   input wire logic [7:0] ucWdata,
   output logic [7:0] ucRdata,
   output logic ucHit,
   // pins and charger conditions
   input wire logic pinFunctionSelect,
   input wire logic sharedLimitPin,
   input wire logic batteryBelowGood,
   input wire logic charging,
   input wire logic cvMode,
   input wire logic atTermCurrent,
   // decoded settings
   output logic [11:0] inputLimitMa,
   output logic inputLimitValid,
   output logic [11:0] chargeCurrentMa,
   output logic [12:0] floatVoltageMv,
   output logic floatVoltageValid,
   output logic [11:0] termCurrentMa,
   output logic [12:0] lockoutMv,
   output logic [11:0] batteryGoodMv,
   output logic recoveryMode,
   output logic [7:0] recoveryCurrentMa,
   output logic chargeDone,
   output logic termTimerRunning
);
   // all register state in one struct
   typedef struct packed {
      logic [7:0] inputLimitConfig;
      logic [7:0] chargeCurrentVoltageConfig;
      logic [7:0] chargeTerminationControl;
      logic [7:0] lockoutRecoverySettings;
      logic [7:0] hostRdata;
      logic [7:0] ucRdata;
   } ccr_bank_s;
   ccr_bank_s st;
   ccr_bank_s next_st;
   // index of the register an offset names, 3'h4 when unmapped
   function automatic logic [2:0] regIndex(input logic [7:0] ofs);
      case (ofs)
         ccr_pkg::OFS_INPUT_LIMIT: regIndex = 3'h0;
         ccr_pkg::OFS_CHARGE_CFG: regIndex = 3'h1;
         ccr_pkg::OFS_TERM_CTL: regIndex = 3'h2;
         ccr_pkg::OFS_LOCKOUT_REC: regIndex = 3'h3;
         default: regIndex = 3'h4;
      endcase
   endfunction
   logic [2:0] hostIdx;
   logic [2:0] ucIdx;
   logic ucPageOk;
   logic [7:0] regs [4];
   assign hostIdx = regIndex(hostAddr);
   assign ucPageOk = (ucAddr[15:8] == ccr_pkg::UC_PAGE);
   assign ucIdx = ucPageOk ? regIndex(ucAddr[7:0]) : 3'h4;
   assign hostHit = !hostIdx[2];
   assign ucHit = !ucIdx[2];
   assign regs[0] = st.inputLimitConfig;
   assign regs[1] = st.chargeCurrentVoltageConfig;
   assign regs[2] = st.chargeTerminationControl;
   assign regs[3] = st.lockoutRecoverySettings;
   // register writes take a whole byte; host wins a same-cycle collision
   always_comb begin
      next_st = st;
      if (ucWrite && ucHit) begin
         case (ucIdx[1:0])
            2'h0: next_st.inputLimitConfig = ucWdata;
            2'h1: next_st.chargeCurrentVoltageConfig = ucWdata;
            2'h2: next_st.chargeTerminationControl = ucWdata;
            default: next_st.lockoutRecoverySettings = ucWdata;
         endcase
      end
      if (hostWrite && hostHit) begin
         case (hostIdx[1:0])
            2'h0: next_st.inputLimitConfig = hostWdata;
            2'h1: next_st.chargeCurrentVoltageConfig = hostWdata;
            2'h2: next_st.chargeTerminationControl = hostWdata;
            default: next_st.lockoutRecoverySettings = hostWdata;
         endcase
      end
      // reads are registered; unmapped reads return zero
      if (hostRead) begin
         next_st.hostRdata = hostHit ? regs[hostIdx[1:0]] : 8'h00;
      end
      if (ucRead) begin
         next_st.ucRdata = ucHit ? regs[ucIdx[1:0]] : 8'h00;
      end
   end
   // state register with documented defaults
   always_ff @(posedge clk) begin
      if (reset) begin
         st.inputLimitConfig <= ccr_pkg::RST_INPUT_LIMIT;
         st.chargeCurrentVoltageConfig <= ccr_pkg::RST_CHARGE_CFG;
         st.chargeTerminationControl <= ccr_pkg::RST_TERM_CTL;
         st.lockoutRecoverySettings <= ccr_pkg::RST_LOCKOUT_REC;
         st.hostRdata <= 8'h00;
         st.ucRdata <= 8'h00;
      end else begin
         st <= next_st;
      end
   end
   assign hostRdata = st.hostRdata;
   assign ucRdata = st.ucRdata;
   // field extraction
   logic [3:0] chargeCurrentCode;
   logic [1:0] floatVoltageCode;
   logic [1:0] terminationMethod;
   logic [4:0] termTimerCode;
   logic [1:0] batteryGoodThreshold;
   logic [2:0] recoveryCurrentCode;
   assign chargeCurrentCode = st.chargeCurrentVoltageConfig[ccr_pkg::CUR_CODE_LSB +: 4];
   assign floatVoltageCode = st.chargeCurrentVoltageConfig[ccr_pkg::VOL_CODE_LSB +: 2];
   assign terminationMethod = st.chargeTerminationControl[ccr_pkg::TERM_METH_LSB +: 2];
   assign termTimerCode = st.chargeTerminationControl[ccr_pkg::TERM_TIMER_LSB +: 5];
   assign batteryGoodThreshold = st.lockoutRecoverySettings[ccr_pkg::BATGD_LSB +: 2];
   assign recoveryCurrentCode = st.lockoutRecoverySettings[ccr_pkg::REC_CUR_LSB +: 3];
   // input limit decode
   ccr_limit_decode uLimit (
      .limitSourceSelect(st.inputLimitConfig[ccr_pkg::LIM_SRC_BIT]),
      .inputLimitCode(st.inputLimitConfig[ccr_pkg::LIM_CODE_LSB +: 3]),
      .pinFunctionSelect(pinFunctionSelect),
      .sharedLimitPin(sharedLimitPin),
      .inputLimitMa(inputLimitMa),
      .inputLimitValid(inputLimitValid)
   );
   // termination timer
   ccr_term_ctrl #(.MINUTE_CYCLES(MINUTE_CYCLES)) uTerm (
      .clk(clk),
      .reset(reset),
      .terminationMethod(terminationMethod),
      .termTimerCode(termTimerCode),
      .charging(charging),
      .cvMode(cvMode),
      .atTermCurrent(atTermCurrent),
      .chargeDone(chargeDone),
      .timerRunning(termTimerRunning)
   );
   // analog settings decoded from the stored fields
   always_comb begin
      // codes 0 and 1 both mean one step
      if (chargeCurrentCode < 4'h2) begin
         chargeCurrentMa = ccr_pkg::MA_100;
      end else begin
         chargeCurrentMa = 12'(chargeCurrentCode) * ccr_pkg::MA_100;
      end
      // code 3 is undefined; flagged, not guessed
      floatVoltageValid = 1'b1;
      case (floatVoltageCode)
         2'h0: floatVoltageMv = ccr_pkg::MV_4100;
         2'h1: floatVoltageMv = ccr_pkg::MV_4150;
         2'h2: floatVoltageMv = ccr_pkg::MV_4200;
         default: begin
            floatVoltageMv = 13'h0000;
            floatVoltageValid = 1'b0;
         end
      endcase
      termCurrentMa = st.chargeTerminationControl[ccr_pkg::TERMINATION_CURRENT_SELECT_BIT]
                    ? ccr_pkg::MA_100 : ccr_pkg::MA_50;
      lockoutMv = st.lockoutRecoverySettings[ccr_pkg::UVLO_BIT] ? ccr_pkg::MV_3950
                : ccr_pkg::MV_4150;
      // 100 mV per step from 2.50 V
      batteryGoodMv = ccr_pkg::MV_2500 + ccr_pkg::MV_100 * 12'(batteryGoodThreshold);
      // 25 mA per step, code 0 same as 1
      if (recoveryCurrentCode == 3'h0) begin
         recoveryCurrentMa = 8'(ccr_pkg::MA_25);
      end else begin
         recoveryCurrentMa = 8'(ccr_pkg::MA_25) * 8'(recoveryCurrentCode);
      end
   end
   // low battery is charged at recovery current instead of CC
   assign recoveryMode = batteryBelowGood;
endmodule // ccr_config_bank
`default_nettype wire

// ---- dv/ccr_config_checker.sv ----
// concurrent checks on the configuration bank ports
`timescale 1ns/1ps
`default_nettype none
module ccr_config_checker (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // register ports
   input wire logic hostWrite,
   input wire logic hostRead,
   input wire logic [7:0] hostAddr,
   input wire logic [7:0] hostWdata,
   input wire logic [7:0] hostRdata,
   input wire logic hostHit,
   input wire logic ucWrite,
   input wire logic [15:0] ucAddr,
   input wire logic ucHit,
   // charger side
   input wire logic batteryBelowGood,
   input wire logic charging,
   input wire logic [11:0] inputLimitMa,
   input wire logic inputLimitValid,
   input wire logic [11:0] chargeCurrentMa,
   input wire logic recoveryMode,
   input wire logic chargeDone,
   input wire logic termTimerRunning
);
   // every check uses the one clock and its reset
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   host_hit_map_a: assert property (hostHit == (hostAddr inside {[8'h90:8'h93]}))
      else $error("host hit decode wrong");
   uc_hit_map_a: assert property (ucHit == (ucAddr inside {[16'hA090:16'hA093]}))
      else $error("controller hit decode wrong");
   unmapped_zero_a: assert property (hostRead && !hostHit |=> hostRdata == 8'h00)
      else $error("unmapped read not zero");
   read_echo_a: assert property (hostWrite && hostHit && !ucWrite
      ##1 !hostWrite && !ucWrite ##1 hostRead && hostAddr == $past(hostAddr, 2)
      |=> hostRdata == $past(hostWdata, 3))
      else $error("read back differs from write");
   rdata_hold_a: assert property (!hostRead |=> $stable(hostRdata))
      else $error("read data moved without read");
   recovery_follow_a: assert property (recoveryMode == batteryBelowGood)
      else $error("recovery mode wrong");
   limit_invalid_a: assert property (!inputLimitValid |-> inputLimitMa == 12'h000)
      else $error("invalid limit not zero");
   charge_range_a: assert property (chargeCurrentMa inside {[12'h064:12'h5DC]})
      else $error("charge current out of range");
   done_clear_a: assert property (!charging |=> !chargeDone && !termTimerRunning)
      else $error("done or timer left set");
   // main scenarios reached
   uc_write_c: cover property (ucWrite && ucHit);
   done_rise_c: cover property ($rose(chargeDone));
   unmapped_read_c: cover property (hostRead && !hostHit);
endmodule // ccr_config_checker
`default_nettype wire

// ---- dv/ccr_host_model.sv ----
// register master model for the host and controller ports
`timescale 1ns/1ps
`default_nettype none
module ccr_host_model (
   // clock
   input wire logic clk,
   // host port
   output logic hostWrite,
   output logic hostRead,
   output logic [7:0] hostAddr,
   output logic [7:0] hostWdata,
   input wire logic [7:0] hostRdata,
   // controller port
   output logic ucWrite,
   output logic ucRead,
   output logic [15:0] ucAddr,
   output logic [7:0] ucWdata,
   input wire logic [7:0] ucRdata
);
   initial begin
      {hostWrite, hostRead, ucWrite, ucRead} = 4'h0;
      {hostAddr, hostWdata, ucAddr, ucWdata} = 32'h0;
   end
   // drop strobes; scramble data so a stale byte is never trusted
   task automatic idle();
      {hostWrite, hostRead, ucWrite, ucRead} = 4'h0;
      hostWdata = ~hostWdata;
      ucWdata = ~ucWdata;
   endtask
   // whole byte per strobe; port 0 host, 1 controller, 2 both at once
   task automatic wr(input int port, input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      hostAddr = a[7:0];
      ucAddr = a;
      hostWdata = d;
      ucWdata = (port == 2) ? ~d : d;
      hostWrite = (port != 1);
      ucWrite = (port != 0);
      @(negedge clk);
      idle();
   endtask
   // read strobe held over one edge, data taken a cycle later
   task automatic rd(input int port, input logic [15:0] a, output logic [7:0] q);
      @(negedge clk);
      hostAddr = a[7:0];
      ucAddr = a;
      hostRead = (port == 0);
      ucRead = (port != 0);
      @(negedge clk);
      q = (port == 0) ? hostRdata : ucRdata;
      idle();
   endtask
endmodule // ccr_host_model
`default_nettype wire

// ---- dv/tb_top.sv ----
// self-checking bench for the charger configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam longint MC = 10; // short minute keeps timer runs brief
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic hostWrite, hostRead, hostHit, ucWrite, ucRead, ucHit;
   logic [7:0] hostAddr, hostWdata, hostRdata, ucWdata, ucRdata, q;
   logic [15:0] ucAddr;
   logic pinFunctionSelect = 1'b0, sharedLimitPin = 1'b0, batteryBelowGood = 1'b0;
   logic charging = 1'b0, cvMode = 1'b0, atTermCurrent = 1'b0;
   logic [11:0] inputLimitMa, chargeCurrentMa, termCurrentMa, batteryGoodMv;
   logic [12:0] floatVoltageMv, lockoutMv;
   logic inputLimitValid, floatVoltageValid, recoveryMode, chargeDone, termTimerRunning;
   logic [7:0] recoveryCurrentMa;
   logic [7:0] regs [4]; // expected register contents
   logic [31:0] k;
   int failures = 0, cmp_count = 0, seed = 32'hd1b4;
   always #10 clk = ~clk;
   ccr_config_bank #(.MINUTE_CYCLES(MC)) i_ccr_config_bank (.clk, .reset, .hostWrite,
      .hostRead, .hostAddr, .hostWdata, .hostRdata, .hostHit, .ucWrite, .ucRead, .ucAddr,
      .ucWdata, .ucRdata, .ucHit, .pinFunctionSelect, .sharedLimitPin, .batteryBelowGood,
      .charging, .cvMode, .atTermCurrent, .inputLimitMa, .inputLimitValid, .chargeCurrentMa,
      .floatVoltageMv, .floatVoltageValid, .termCurrentMa, .lockoutMv, .batteryGoodMv,
      .recoveryMode, .recoveryCurrentMa, .chargeDone, .termTimerRunning);
   ccr_host_model host (.clk, .hostWrite, .hostRead, .hostAddr, .hostWdata, .hostRdata,
      .ucWrite, .ucRead, .ucAddr, .ucWdata, .ucRdata);
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("compares=%0d failures=%0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // expected input limit from source bit, pin function and pin level
   function automatic logic [11:0] lim(input logic [7:0] r, input logic fn, input logic pin);
      if (!r[7]) return !fn ? 12'h000 : (pin ? 12'h5DC : 12'h1F4);
      case (r[2:0])
         3'h0: return 12'h064;
         3'h1: return 12'h1F4;
         3'h2: return 12'h3E8;
         3'h3: return 12'h5DC;
         3'h4: return 12'h7D0;
         default: return 12'h000;
      endcase
   endfunction
   // compare every decoded setting but chargeDone and termTimerRunning with the expected registers
   task automatic chk_dec();
      logic [11:0] e;
      e = lim(regs[0], pinFunctionSelect, sharedLimitPin);
      chk(inputLimitMa, e);
      chk(inputLimitValid, e != 12'h000);
      chk(chargeCurrentMa, (regs[1][3:0] < 4'h2) ? 12'h064 : 12'(regs[1][3:0]) * 12'h064);
      chk(floatVoltageValid, regs[1][5:4] != 2'h3);
      chk(floatVoltageMv, (regs[1][5:4] == 2'h3) ? 13'h0000 : 13'h1004 + 13'(regs[1][5:4]) * 13'h0032);
      chk(termCurrentMa, regs[2][7] ? 12'h064 : 12'h032);
      chk(lockoutMv, regs[3][0] ? 13'h0F6E : 13'h1036);
      chk(batteryGoodMv, 12'h9C4 + 12'(regs[3][4:3]) * 12'h064);
      chk(recoveryCurrentMa, (regs[3][7:5] < 3'h2) ? 8'h19 : 8'(regs[3][7:5]) * 8'h19);
      chk(recoveryMode, batteryBelowGood);
   endtask
   task automatic put(input int port, input int i, input logic [7:0] d);
      host.wr(port, 16'hA090 + 16'(i), d);
      regs[i] = d;
   endtask
   task automatic get_chk(input int port, input logic [15:0] a, input logic [7:0] exp);
      host.rd(port, a, q);
      chk(q, exp);
   endtask
   // software keeps random bytes off the invalid limit and voltage codes
   function automatic logic [7:0] legal(input int i, input logic [7:0] d);
      if (i == 0 && d[7] && d[2:0] > 3'h4) d[2] = 1'b0;
      if (i == 1 && d[5:4] == 2'h3) d[5] = 1'b0;
      return d;
   endfunction
   // run the charger with a method setting; n is cycles to done, 0 for never
   task automatic term(input logic [7:0] r2, input logic cv, input logic at, input int n);
      put(0, 2, r2);
      {charging, cvMode, atTermCurrent} = {1'b1, cv, at};
      repeat ((n > 12) ? n - 12 : 30) @(negedge clk);
      if (n == 0 || n > 12) chk(chargeDone, 1'b0);
      if (n == 0) chk(termTimerRunning, 1'b0);
      if (n > 12) chk(termTimerRunning, 1'b1);
      for (int c = 0; c < 16 && n != 0 && chargeDone !== 1'b1; c++) @(negedge clk);
      if (n != 0) chk(chargeDone, 1'b1);
      {charging, cvMode, atTermCurrent} = 3'h0;
      @(negedge clk);
      chk(chargeDone, 1'b0);
   endtask
   initial begin
      regs = '{8'h80, 8'h00, 8'h04, 8'h78};
      repeat (6) @(negedge clk);
      reset = 1'b0;
      for (int i = 0; i < 8; i++) get_chk(i / 4, 16'hA090 + 16'(i % 4), regs[i % 4]);
      chk_dec();
      host.wr(0, 16'h0094, 8'hFF);
      host.wr(1, 16'h0091, 8'hFF);
      get_chk(0, 16'h0094, 8'h00);
      get_chk(1, 16'h0091, 8'h00);
      get_chk(0, 16'h0091, regs[1]);
      for (int i = 0; i < 12; i++) begin
         {pinFunctionSelect, sharedLimitPin} = 2'(i);
         put(i % 2, 0, (i < 8) ? 8'h80 | 8'(i) : 8'h00);
         chk_dec();
      end
      for (int i = 0; i < 16; i++) begin
         for (int r = 1; r < 4; r++) put(r % 2, r, 8'(i * 17));
         chk_dec();
      end
      for (int n = 0; n < 60; n++) begin
         k = $random(seed);
         k[7:0] = legal(k[14:13], k[7:0]);
         {pinFunctionSelect, sharedLimitPin, batteryBelowGood} = k[10:8];
         put(k[12], k[14:13], k[7:0]);
         get_chk(0, 16'h0090 + 16'(k[14:13]), k[7:0]);
         chk_dec();
      end
      put(2, 1, 8'h5A);
      get_chk(1, 16'hA091, 8'h5A);
      term(8'h0C, 1'b0, 1'b1, 60);
      term(8'h0C, 1'b1, 1'b0, 0);
      term(8'h05, 1'b1, 1'b0, 100);
      term(8'h86, 1'b1, 1'b0, 0);
      term(8'h86, 1'b1, 1'b1, 2);
      term(8'hFF, 1'b1, 1'b1, 2);
      term(8'h07, 1'b1, 1'b0, 100);
      end_of_test();
   end
   // cut a hang short well past the expected run length
   initial begin
      #(20 * 20000);
      failures++;
      end_of_test();
   end
endmodule // tb_top
bind ccr_config_bank ccr_config_checker i_ccr_config_checker (.clk, .reset, .hostWrite,
   .hostRead, .hostAddr, .hostWdata, .hostRdata, .hostHit, .ucWrite, .ucAddr, .ucHit,
   .batteryBelowGood, .charging, .inputLimitMa, .inputLimitValid, .chargeCurrentMa,
   .recoveryMode, .chargeDone, .termTimerRunning);
`default_nettype wire
